//--- eeprom_slave.sv
`timescale 1ns/1ps
// Functional notes
// - data changes only while clock low
// - falling data, clock high: new transaction starts
// - rising data, clock high: stop, then standby
// - eight-bit words, ack low on ninth clock
// - standby at reset and after stop
// - device word needs fixed five-bit prefix
// - two select bits match strapped select pins
// - eighth bit high reads, low writes
// - match acks low; mismatch no ack, standby
// - write protect high blocks all array writes
// - byte write: device, two address, one data
// - stop after write starts timed cycle, deaf
// - timed write ends within documented time
// - page write up to 128 bytes, each acked
// - only low seven address bits advance on write
// - polling acks only once write has finished
// - counter keeps last address plus one, wraps
// - read continues while master acks each byte
module eeprom_slave #(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::NV_WRITE_CYCLES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // two-wire bus
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // straps and protection
   input wire logic i_device_select_high,
   input wire logic i_device_select_low,
   input wire logic i_write_protect,
   // status
   output logic o_standby,
   output logic o_write_busy
);
   // ****************************************************************
   // local sizes
   // ****************************************************************
   localparam int AW = eeprom_pkg::ADDR_W;
   localparam int PW = eeprom_pkg::PAGE_W;
   localparam int DEPTH = 1 << AW;
   localparam int WCNT_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WRITE_CYCLES - 1);
   localparam logic [WCNT_W-1:0] WCNT_PAGE =
      WCNT_W'(eeprom_pkg::PAGE_BYTES);

   // ****************************************************************
   // storage
   // ****************************************************************
   logic [7:0] mem [DEPTH]; // nonvolatile array, never reset
   logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES]; // pending page bytes
   logic [eeprom_pkg::PAGE_BYTES-1:0] mask_q; // which bytes are pending

   // ****************************************************************
   // state
   // ****************************************************************
   eeprom_pkg::proto_state_t state_q; // protocol position
   logic [3:0] cnt_q; // bits moved in the current word
   logic [7:0] shreg_q; // shift register, in or out
   logic mack_q; // master answer after a read byte
   logic [AW-1:0] addr_q; // internal address counter
   logic oe_q; // pulling data low
   logic sda_q; // open-drain output level, always low
   logic busy_q; // self-timed write in progress
   logic [WCNT_W-1:0] wcnt_q; // write cycle timer
   logic standby_q; // standby flag
   logic busy_out_q; // busy flag copy for the port

   // ****************************************************************
   // pin sampling
   // ****************************************************************
   line_events_if ev ();

   line_sampler u_sampler (
      .i_clk (i_clk),
      .i_arst_n (i_arst_n),
      .i_scl (i_scl),
      .i_sda (i_sda),
      .i_wp (i_write_protect),
      .i_sel_high (i_device_select_high),
      .i_sel_low (i_device_select_low),
      .ev (ev.src)
   );

   // ****************************************************************
   // decode shared by the processes
   // ****************************************************************
   logic active; // not deaf
   logic rx_state; // a word is being shifted in
   logic byte_in; // falling edge right after eighth bit in
   logic dev_match; // device word addresses this part
   logic rd_first; // first read byte loads now
   logic rd_next; // further read byte loads now
   logic commit_go; // stop closes a write with bytes pending
   logic [7:0] rd_byte; // byte at the address counter

   always_comb begin
      // inputs are dropped entirely while the timed write runs
      active = ~busy_q;
      rx_state = (state_q == eeprom_pkg::ST_DEV)
              || (state_q == eeprom_pkg::ST_ADDR_HI)
              || (state_q == eeprom_pkg::ST_ADDR_LO)
              || (state_q == eeprom_pkg::ST_WDATA);
      byte_in = active && ev.scl_fall && rx_state
             && (cnt_q == eeprom_pkg::CNT_FULL);
      dev_match = (shreg_q[eeprom_pkg::PREFIX_MSB:eeprom_pkg::PREFIX_LSB]
                   == eeprom_pkg::DEV_PREFIX)
               && (shreg_q[eeprom_pkg::SEL_MSB:eeprom_pkg::SEL_LSB]
                   == ev.sel);
      rd_first = active && ev.scl_fall
              && (state_q == eeprom_pkg::ST_DEV_ACK)
              && shreg_q[eeprom_pkg::RW_BIT];
      rd_next = active && ev.scl_fall
             && (state_q == eeprom_pkg::ST_RDATA_ACK) && ~mack_q;
      // the stop follows one sampled clock, so zero or one bit is clean
      commit_go = active && ev.stop
               && (state_q == eeprom_pkg::ST_WDATA)
               && (cnt_q <= eeprom_pkg::CNT_ONE)
               && (|mask_q) && ~ev.wp;
      rd_byte = mem[addr_q];
   end

   // ****************************************************************
   // protocol sequencer and shift register
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= eeprom_pkg::ST_IDLE;
         cnt_q <= eeprom_pkg::CNT_ZERO;
         shreg_q <= 8'h00;
         mack_q <= 1'b1;
      end else if (!active) begin
         state_q <= eeprom_pkg::ST_IDLE;
         cnt_q <= eeprom_pkg::CNT_ZERO;
      end else if (ev.start) begin
         // restart anywhere drops the word in flight
         state_q <= eeprom_pkg::ST_DEV;
         cnt_q <= eeprom_pkg::CNT_ZERO;
      end else if (ev.stop) begin
         state_q <= eeprom_pkg::ST_IDLE;
         cnt_q <= eeprom_pkg::CNT_ZERO;
      end else begin
         unique case (state_q)
            eeprom_pkg::ST_IDLE,
            eeprom_pkg::ST_IGNORE: begin
               // wait for the next start
            end
            eeprom_pkg::ST_DEV,
            eeprom_pkg::ST_ADDR_HI,
            eeprom_pkg::ST_ADDR_LO,
            eeprom_pkg::ST_WDATA: begin
               if (ev.scl_rise && cnt_q != eeprom_pkg::CNT_FULL) begin
                  shreg_q <= {shreg_q[6:0], ev.sda};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_in) begin
                  unique case (state_q)
                     eeprom_pkg::ST_DEV: begin
                        // a mismatch leaves the bus alone
                        state_q <= dev_match ? eeprom_pkg::ST_DEV_ACK
                                             : eeprom_pkg::ST_IDLE;
                     end
                     eeprom_pkg::ST_ADDR_HI: begin
                        state_q <= eeprom_pkg::ST_HI_ACK;
                     end
                     eeprom_pkg::ST_ADDR_LO: begin
                        state_q <= eeprom_pkg::ST_LO_ACK;
                     end
                     default: begin
                        state_q <= eeprom_pkg::ST_WDATA_ACK;
                     end
                  endcase
               end
            end
            eeprom_pkg::ST_DEV_ACK: begin
               if (ev.scl_fall) begin
                  cnt_q <= eeprom_pkg::CNT_ZERO;
                  if (rd_first) begin
                     state_q <= eeprom_pkg::ST_RDATA;
                     shreg_q <= rd_byte;
                  end else begin
                     state_q <= eeprom_pkg::ST_ADDR_HI;
                  end
               end
            end
            eeprom_pkg::ST_HI_ACK: begin
               if (ev.scl_fall) begin
                  state_q <= eeprom_pkg::ST_ADDR_LO;
                  cnt_q <= eeprom_pkg::CNT_ZERO;
               end
            end
            eeprom_pkg::ST_LO_ACK,
            eeprom_pkg::ST_WDATA_ACK: begin
               if (ev.scl_fall) begin
                  state_q <= eeprom_pkg::ST_WDATA;
                  cnt_q <= eeprom_pkg::CNT_ZERO;
               end
            end
            eeprom_pkg::ST_RDATA: begin
               if (ev.scl_fall) begin
                  if (cnt_q == eeprom_pkg::CNT_LAST_TX) begin
                     state_q <= eeprom_pkg::ST_RDATA_ACK;
                  end else begin
                     shreg_q <= {shreg_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            eeprom_pkg::ST_RDATA_ACK: begin
               if (ev.scl_rise) begin
                  mack_q <= ev.sda;
               end else if (ev.scl_fall) begin
                  cnt_q <= eeprom_pkg::CNT_ZERO;
                  if (rd_next) begin
                     state_q <= eeprom_pkg::ST_RDATA;
                     shreg_q <= rd_byte;
                  end else begin
                     // no ack from master: hands off until the next start or stop
                     state_q <= eeprom_pkg::ST_IGNORE;
                  end
               end
            end
            default: begin
               state_q <= eeprom_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // data line drive, set on clock falls, released at start, stop or timed write
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         oe_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         sda_q <= 1'b0;
         if (!active || ev.start || ev.stop) begin
            oe_q <= 1'b0;
         end else if (ev.scl_fall) begin
            if (byte_in) begin
               // ack every word except a foreign device word
               oe_q <= (state_q != eeprom_pkg::ST_DEV) || dev_match;
            end else if (rd_first || rd_next) begin
               oe_q <= ~rd_byte[7];
            end else if (state_q == eeprom_pkg::ST_RDATA
                         && cnt_q != eeprom_pkg::CNT_LAST_TX) begin
               oe_q <= ~shreg_q[6];
            end else begin
               // ack slot over, or master's ack slot: release
               oe_q <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // address counter
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         addr_q <= eeprom_pkg::ADDR_RESET;
      end else if (byte_in && state_q == eeprom_pkg::ST_ADDR_HI) begin
         addr_q[AW-1:8] <= shreg_q;
      end else if (byte_in && state_q == eeprom_pkg::ST_ADDR_LO) begin
         addr_q[7:0] <= shreg_q;
      end else if (byte_in && state_q == eeprom_pkg::ST_WDATA) begin
         // page bits stay, offset rolls inside the page
         addr_q[PW-1:0] <= addr_q[PW-1:0] + 7'h01;
      end else if (active && ev.scl_fall
                   && state_q == eeprom_pkg::ST_RDATA
                   && cnt_q == eeprom_pkg::CNT_LAST_TX) begin
         // full-width add rolls from last byte of array to first
         addr_q <= addr_q + 16'h0001;
      end
   end

   // ****************************************************************
   // page buffer: array untouched until a clean stop
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (byte_in && state_q == eeprom_pkg::ST_WDATA) begin
         page_buf[addr_q[PW-1:0]] <= shreg_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mask_q <= '0;
      end else if (busy_q) begin
         if (wcnt_q == WCNT_LAST) begin
            mask_q <= '0;
         end
      end else if (byte_in && state_q == eeprom_pkg::ST_WDATA) begin
         mask_q[addr_q[PW-1:0]] <= 1'b1;
      end else if ((ev.start || ev.stop) && !commit_go) begin
         // an unfinished or protected write leaves no trace
         mask_q <= '0;
      end
   end

   // ****************************************************************
   // self-timed write: copy page, then run out the cycle time
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy_q <= 1'b0;
         wcnt_q <= '0;
      end else if (commit_go) begin
         busy_q <= 1'b1;
         wcnt_q <= '0;
      end else if (busy_q) begin
         wcnt_q <= wcnt_q + WCNT_W'(1);
         if (wcnt_q == WCNT_LAST) begin
            busy_q <= 1'b0;
         end
      end
   end

   // one pending byte per cycle during the first page-length cycles
   always_ff @(posedge i_clk) begin
      if (busy_q && wcnt_q < WCNT_PAGE && mask_q[wcnt_q[PW-1:0]]) begin
         mem[{addr_q[AW-1:PW], wcnt_q[PW-1:0]}] <=
            page_buf[wcnt_q[PW-1:0]];
      end
   end

   // ****************************************************************
   // status flags
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         standby_q <= 1'b1;
         busy_out_q <= 1'b0;
      end else begin
         standby_q <= (state_q == eeprom_pkg::ST_IDLE) && ~busy_q;
         busy_out_q <= busy_q;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_sda = sda_q;
   assign o_sda_oe = oe_q;
   assign o_standby = standby_q;
   assign o_write_busy = busy_out_q;
endmodule : eeprom_slave

//--- eeprom_pkg.sv
package eeprom_pkg;
   // ****************************************************************
   // array geometry
   // ****************************************************************
   localparam int ADDR_W = 16; // word address width, whole array
   localparam int PAGE_W = 7; // in-page offset width
   localparam int PAGE_BYTES = 128; // bytes held by one page
   localparam int BYTE_BITS = 8; // bits in one serial word
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000; // counter at reset

   // ****************************************************************
   // device address word layout
   // ****************************************************************
   localparam logic [4:0] DEV_PREFIX = 5'h14; // fixed ones/zeros prefix
   localparam int PREFIX_MSB = 7; // prefix field top bit
   localparam int PREFIX_LSB = 3; // prefix field low bit
   localparam int SEL_MSB = 2; // select field top bit
   localparam int SEL_LSB = 1; // select field low bit
   localparam int RW_BIT = 0; // high = read, low = write

   // ****************************************************************
   // bit counter marks
   // ****************************************************************
   localparam logic [3:0] CNT_ZERO = 4'h0; // no bit taken yet
   localparam logic [3:0] CNT_ONE = 4'h1; // one bit taken
   localparam logic [3:0] CNT_LAST_TX = 4'h7; // last bit driven out
   localparam logic [3:0] CNT_FULL = 4'h8; // whole word shifted in

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 25; // system clock period
   localparam int NV_WRITE_TIME_US = 5000; // longest self-timed write
   // longest time, so the division rounds down
   localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_US * 1000)
                                    / CLK_PERIOD_NS;

   // ****************************************************************
   // protocol states, gray along the byte write path and the read data loop
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_DEV = 4'h1,
      ST_DEV_ACK = 4'h3,
      ST_ADDR_HI = 4'h2,
      ST_HI_ACK = 4'h6,
      ST_ADDR_LO = 4'h7,
      ST_LO_ACK = 4'h5,
      ST_WDATA = 4'h4,
      ST_WDATA_ACK = 4'hC,
      ST_RDATA = 4'hD,
      ST_RDATA_ACK = 4'hF,
      ST_IGNORE = 4'hE
   } proto_state_t;
endpackage : eeprom_pkg

//--- line_events_if.sv
`timescale 1ns/1ps
// events and clean levels from the bus pins, in the system clock domain
interface line_events_if;
   logic scl_rise; // one-cycle pulse on a clock rising edge
   logic scl_fall; // one-cycle pulse on a clock falling edge
   logic start; // data fell while clock high
   logic stop; // data rose while clock high
   logic sda; // synchronised data level
   logic wp; // synchronised write protect level
   logic [1:0] sel; // synchronised select straps, high then low

   modport src (output scl_rise, scl_fall, start, stop, sda, wp, sel);
   modport dst (input scl_rise, scl_fall, start, stop, sda, wp, sel);
endinterface : line_events_if

//--- line_sampler.sv
`timescale 1ns/1ps
// two-flop synchronisers for every pin plus edge and condition detect
module line_sampler (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // raw pins
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_wp,
   input wire logic i_sel_high,
   input wire logic i_sel_low,
   // events out
   line_events_if.src ev
);
   // ****************************************************************
   // synchronisers
   // ****************************************************************
   logic [4:0] meta_q; // first stage, read only by second stage
   logic [4:0] sync_q; // second stage, safe to use
   logic scl_old_q; // previous clean clock level
   logic sda_old_q; // previous clean data level

   // bus lines idle high, so they reset high to avoid a false event
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= 5'h03;
         sync_q <= 5'h03;
         scl_old_q <= 1'b1;
         sda_old_q <= 1'b1;
      end else begin
         meta_q <= {i_sel_high, i_sel_low, i_wp, i_sda, i_scl};
         sync_q <= meta_q;
         scl_old_q <= sync_q[0];
         sda_old_q <= sync_q[1];
      end
   end

   // ****************************************************************
   // edge and condition decode
   // ****************************************************************
   // both clock samples high: a data edge here is a condition, not data
   assign ev.scl_rise = sync_q[0] & ~scl_old_q;
   assign ev.scl_fall = ~sync_q[0] & scl_old_q;
   assign ev.start = sync_q[0] & scl_old_q & sda_old_q & ~sync_q[1];
   assign ev.stop = sync_q[0] & scl_old_q & ~sda_old_q & sync_q[1];
   assign ev.sda = sync_q[1];
   assign ev.wp = sync_q[2];
   assign ev.sel = sync_q[4:3];
endmodule : line_sampler

//--- eeprom_slave_monitor.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker for the eeprom slave
// ****************************************************************
module eeprom_slave_monitor #(
   parameter int unsigned WRITE_CYCLES = 200
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe,
   // straps, protection and status
   input wire logic i_device_select_high,
   input wire logic i_device_select_low,
   input wire logic i_write_protect,
   input wire logic o_standby,
   input wire logic o_write_busy
);
   logic scl_q; // clock pin one cycle back
   logic sda_q; // data pin one cycle back
   logic [3:0] since_stop_q; // cycles since a stop, saturates
   int unsigned busy_len_q; // cycles of the running write
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   // raw pins, seen without the synchroniser lag of the design
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end
   // stop age saturates so an old stop never looks young again
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) since_stop_q <= 4'hF;
      else if (scl_q && i_scl && !sda_q && i_sda) since_stop_q <= 4'h0;
      else if (since_stop_q != 4'hF) since_stop_q <= since_stop_q + 4'h1;
   end
   // length of the running busy period
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) busy_len_q <= 0;
      else busy_len_q <= o_write_busy ? busy_len_q + 1 : 0;
   end
   sda_low_only_a: assert property (o_sda == 1'b0)
      else $error("data output not held low");
   reset_idle_a: assert property ($rose(i_arst_n) |->
      o_standby && !o_write_busy && !o_sda_oe)
      else $error("not idle after reset");
   busy_standby_a: assert property (o_write_busy |-> !o_standby)
      else $error("standby during write");
   busy_quiet_a: assert property (o_write_busy |-> !o_sda_oe)
      else $error("data driven during write");
   busy_after_stop_a: assert property ($rose(o_write_busy) |->
      since_stop_q <= 4'h8)
      else $error("write began without a stop");
   busy_length_a: assert property ($fell(o_write_busy) |->
      busy_len_q == WRITE_CYCLES)
      else $error("write time wrong");
   protect_block_a: assert property ($rose(o_write_busy) |->
      !$past(i_write_protect, 8))
      else $error("write while protected");
   drive_steady_a: assert property (i_scl && $past(i_scl) &&
      $past(i_scl, 2) |-> $stable(o_sda_oe))
      else $error("data moved while clock high");
endmodule : eeprom_slave_monitor
bind eeprom_slave eeprom_slave_monitor #(.WRITE_CYCLES(WRITE_CYCLES))
   eeprom_slave_monitor_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
   .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .i_device_select_high(i_device_select_high),
   .i_device_select_low(i_device_select_low),
   .i_write_protect(i_write_protect), .o_standby(o_standby),
   .o_write_busy(o_write_busy));

//--- bus_master_model.sv
`timescale 1ns/1ps
// ****************************************************************
// behavioural two-wire bus master, timed by delays
// ****************************************************************
module bus_master_model (
   // data wire level
   input wire logic i_sda,
   // clock and data pull-down
   output logic o_scl,
   output logic o_sda_oe
);
   int stretch = 0; // extra low time per bit, a slow master
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // one bit; data moves only while the clock is low
   task automatic put_bit(input logic b, output logic r);
      #(50 + stretch);
      o_sda_oe = !b;
      #50 o_scl = 1'b1;
      #50 r = i_sda;
      #50 o_scl = 1'b0;
   endtask : put_bit
   // start or restart; the 5 ns skew keeps pins off the clock edge
   task automatic start();
      #55 o_sda_oe = 1'b0;
      #50 o_scl = 1'b1;
      #50 o_sda_oe = 1'b1;
      #50 o_scl = 1'b0;
   endtask : start
   task automatic stop();
      #50 o_sda_oe = 1'b1;
      #50 o_scl = 1'b1;
      #50 o_sda_oe = 1'b0;
      #45;
   endtask : stop
   // n bits msb first; the ack bit only after a whole byte
   task automatic send(input logic [7:0] b, input int n, output logic ack);
      logic r;
      for (int i = 7; i > 7 - n; i--) put_bit(b[i], r);
      ack = 1'b1;
      if (n == 8) put_bit(1'b1, ack);
   endtask : send
   // read a byte, ack low to go on, high to end
   task automatic recv(input logic more, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
      put_bit(!more, r);
   endtask : recv
   // bus recovery: nine clocks, data released, then start
   task automatic recover();
      logic r;
      #5 repeat (9) put_bit(1'b1, r);
      start();
   endtask : recover
endmodule : bus_master_model

//--- test_eeprom_slave.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench with a behavioural array model
// ****************************************************************
module test_eeprom_slave;
   localparam int unsigned WR = 200; // shortened write time
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic wp = 1'b0;
   logic sel_hi = 1'b0;
   logic sel_lo = 1'b0;
   logic scl, m_oe, d_oe, d_sda, sda, standby, busy;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   logic [7:0] mem [int]; // expected array contents
   int ptr = 0; // expected address counter
   assign sda = !(m_oe || (d_oe && !d_sda)); // open drain, pull-up
   eeprom_slave #(.WRITE_CYCLES(WR)) eeprom_slave_inst (.i_clk(i_clk),
      .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda), .o_sda(d_sda),
      .o_sda_oe(d_oe), .i_device_select_high(sel_hi),
      .i_device_select_low(sel_lo), .i_write_protect(wp),
      .o_standby(standby), .o_write_busy(busy));
   bus_master_model bm (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
   always #12.5 i_clk = ~i_clk;
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // hang guard, well above the expected run length
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic check(input string n, input logic [15:0] s,
         input logic [15:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : check
   function automatic logic [7:0] dw(input logic rw);
      return {eeprom_pkg::DEV_PREFIX, sel_hi, sel_lo, rw};
   endfunction : dw
   task automatic put(input logic [7:0] b);
      logic ack;
      bm.send(b, 8, ack);
      check("ack", 16'(ack), 16'h0000);
   endtask : put
   // after a stop: busy as expected, then ack polling
   task automatic settle(input logic exp);
      logic ack;
      repeat (10) @(posedge i_clk);
      check("busy", 16'(busy), 16'(exp));
      if (exp) begin
         bm.start();
         bm.send(dw(1'b0), 8, ack);
         check("poll", 16'(ack), 16'h0001);
         for (int i = 0; i < WR && busy !== 1'b0; i++) @(posedge i_clk);
         check("busy end", 16'(busy), 16'h0000);
         bm.start();
         put(dw(1'b0));
         bm.stop();
      end
   endtask : settle
   // write or read n bytes, optionally loading the address first
   task automatic xfer(input logic rd, input logic seta,
         input logic [15:0] a, input int n);
      logic [7:0] b;
      bm.start();
      if (seta) begin
         put(dw(1'b0));
         put(a[15:8]);
         put(a[7:0]);
         ptr = a;
      end
      if (rd && seta) bm.start();
      if (rd) put(dw(1'b1));
      for (int i = 0; i < n; i++) begin
         if (rd) begin
            bm.recv(i < n - 1, b);
            check("read", 16'(b), 16'(mem[ptr]));
            ptr = (ptr + 1) & 16'hFFFF;
         end else begin
            b = 8'($urandom);
            put(b);
            if (!wp) mem[{a[15:7], 7'(a[6:0] + i)}] = b;
         end
      end
      if (!rd) ptr = {a[15:7], 7'(a[6:0] + n)};
      bm.stop();
      repeat (6) @(posedge i_clk);
      if (rd) check("standby", 16'(standby), 16'h0001);
   endtask : xfer
   initial begin
      logic ack;
      void'($urandom(32'h2410E63E));
      repeat (4) @(posedge i_clk);
      i_arst_n <= 1'b1;
      {sel_hi, sel_lo} <= 2'($urandom);
      repeat (4) @(posedge i_clk);
      check("standby", 16'(standby), 16'h0001);
      bm.recover();
      bm.stop();
      // every select code, then a wrong prefix
      for (int s = 0; s < 5; s++) begin
         bm.start();
         bm.send({s == 4 ? 5'h15 : eeprom_pkg::DEV_PREFIX,
            s == 4 ? {sel_hi, sel_lo} : 2'(s), 1'b0}, 8, ack);
         check("select", 16'(ack),
            16'(!(s < 4 && 2'(s) == {sel_hi, sel_lo})));
         bm.stop();
      end
      xfer(1'b0, 1'b1, {9'($urandom), 7'($urandom_range(0, 99))}, 130);
      settle(1'b1);
      xfer(1'b1, 1'b0, 16'h0000, 3);
      bm.stretch = 300;
      xfer(1'b0, 1'b1, 16'hFFFF, 1);
      settle(1'b1);
      xfer(1'b0, 1'b1, 16'h0000, 1);
      settle(1'b1);
      bm.stretch = 0;
      xfer(1'b1, 1'b1, 16'hFFFF, 2);
      @(posedge i_clk) wp <= 1'b1;
      xfer(1'b0, 1'b1, 16'h0000, 1);
      settle(1'b0);
      @(posedge i_clk) wp <= 1'b0;
      xfer(1'b1, 1'b1, 16'h0000, 1);
      // a stop in mid-byte drops the whole write
      bm.start();
      put(dw(1'b0));
      put(8'h00);
      put(8'h00);
      put(~mem[0]);
      bm.send(8'hA5, 4, ack);
      bm.stop();
      settle(1'b0);
      xfer(1'b1, 1'b1, 16'h0000, 1);
      print_verdict();
   end
endmodule : test_eeprom_slave
